// [src/errcode_former.sv]
// forms the segment-related error code word
`timescale 1ns/1ns
`include "exc_consts.svh"
module errcode_former
(
	errcode_if.former ec
);
	always_comb
	begin
		ec.code                = 32'h0000_0000;
		ec.code[`ERR_EXT_BIT]  = ec.external_event_bit;
		ec.code[`ERR_TBL_BIT]  = ec.in_table;
		// table indicator only has meaning outside the vector table
		ec.code[`ERR_TI_BIT]   = ec.in_table ? 1'b0 : ec.local_tbl;
		ec.code[15:`ERR_IDX_LO] = ec.index;
	end
endmodule // errcode_former

// [src/errcode_if.sv]
// carrier between dispatch core and error code former
`timescale 1ns/1ns
interface errcode_if;
	logic        external_event_bit;
	logic        in_table;
	logic        local_tbl;
	logic [12:0] index;
	logic [31:0] code;
	modport former (input external_event_bit, input in_table, input local_tbl, input index, output code);
	modport user (output external_event_bit, output in_table, output local_tbl, output index, input code);
endinterface

// [src/exc_consts.svh]
// constant definitions for the exception dispatch block
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH
// ********************
// register byte offsets
// ********************
`define OFS_REQ      8'h00
`define OFS_FLAGS    8'h04
`define OFS_GATE     8'h08
`define OFS_CPL      8'h0c
`define OFS_SEL      8'h10
`define OFS_STATUS   8'h14
`define OFS_SAVED    8'h18
`define OFS_ERRC     8'h1c
`define OFS_RETURN_FROM_INTERRUPT     8'h20
`define OFS_DIVIDEND 8'h24
`define OFS_DIVISOR  8'h28
`define OFS_QUOT     8'h2c
`define OFS_TASK     8'h30
`define OFS_LINK     8'h34
`define OFS_IP       8'h38
`define OFS_NEXT_IP  8'h3c
`define OFS_HWVEC    8'h40
// ********************
// flag positions in the flags register
// ********************
`define TRACE_BIT    8
`define IE_BIT       9
`define NEST_BIT     14
`define RESUME_BIT   16
`define V86_BIT      17
`define FLAGS_RESET  32'h0000_0002
// ********************
// fields
// ********************
`define SRC_EXC      3'h0
`define SRC_PIN      3'h1
`define SRC_SOFT     3'h2
`define SRC_BRK      3'h3
`define SRC_OVF      3'h4
`define KIND_INT     2'h0
`define KIND_TRAP    2'h1
`define KIND_TASK    2'h2
`define DIVIDE_VEC   8'h00
`define ERR_EXT_BIT  0
`define ERR_TBL_BIT  1
`define ERR_TI_BIT   2
`define ERR_IDX_LO   3
`define DIV_SIGN_BIT 16
`endif

// [src/exc_dispatch.sv]
// exception and interrupt dispatch unit with apb register access
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "exc_consts.svh"
module exc_dispatch
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        maskable_interrupt_pin,
	input  wire logic        push_ready,
	output logic             push_valid,
	output logic      [31:0] push_data,
	output logic             push_wide,
	output logic             task_switch,
	output logic             gp_fault
);
	// ********************
	// decode helpers
	// ********************
	function automatic logic addr_hit(input logic [7:0] a);
		case (a)
			`OFS_REQ, `OFS_FLAGS, `OFS_GATE, `OFS_CPL, `OFS_SEL, `OFS_STATUS,
			`OFS_SAVED, `OFS_ERRC, `OFS_RETURN_FROM_INTERRUPT, `OFS_DIVIDEND, `OFS_DIVISOR,
			`OFS_QUOT, `OFS_TASK, `OFS_LINK, `OFS_IP, `OFS_NEXT_IP, `OFS_HWVEC:
				addr_hit = 1'b1;
			default:
				addr_hit = 1'b0;
		endcase
	endfunction

	function automatic exc_pkg::src_t src_decode(input logic [2:0] c);
		case (c)
			`SRC_PIN:  src_decode = exc_pkg::src_pin;
			`SRC_SOFT: src_decode = exc_pkg::src_soft;
			`SRC_BRK:  src_decode = exc_pkg::src_brk;
			`SRC_OVF:  src_decode = exc_pkg::src_ovf;
			default:   src_decode = exc_pkg::src_exc;
		endcase
	endfunction

	// ********************
	// state
	// ********************
	exc_pkg::disp_state_t state_reg, state_next;
	exc_pkg::src_t        src_reg, src_next;
	logic [31:0] flags_reg, flags_next;
	logic [31:0] gate_reg, gate_next;
	logic [1:0]  cpl_reg, cpl_next;
	logic [14:0] sel_reg, sel_next;
	logic [31:0] saved_reg, saved_next;
	logic [31:0] errc_reg, errc_next;
	logic [31:0] dividend_reg, dividend_next;
	logic [16:0] divisor_reg, divisor_next;
	logic [15:0] quot_reg, quot_next;
	logic [15:0] task_reg, task_next;
	logic [15:0] link_reg, link_next;
	logic [31:0] ip_reg, ip_next;
	logic [31:0] next_ip_reg, next_ip_next;
	logic [7:0]  hwvec_reg, hwvec_next;
	logic [7:0]  vec_reg, vec_next;
	logic        err_reg, err_next;
	logic        ext_reg, ext_next;
	logic [4:0]  status_reg, status_next;
	logic        ts_reg, ts_next;
	logic        gp_reg, gp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        pin_s1_reg, pin_s2_reg;

	logic        wr_en;
	logic        rd_sel;
	logic        start;
	logic        pin_take;
	logic        div_fault;
	logic        priv_fail;
	logic        sw_src;
	logic [31:0] quot_full;
	logic [31:0] rdata_mux;

	errcode_if ec ();

	errcode_former u_former
	(
		.ec (ec)
	);

	// ********************
	// apb slave: zero wait states, unmapped address answers with error
	// ********************
	assign wr_en   = psel && penable && pwrite && ce;
	assign rd_sel  = psel && ce;
	assign pready  = psel && penable && ce;
	assign pslverr = psel && penable && ce && !addr_hit(paddr);
	assign prdata  = rdata_reg;

	always_comb
	begin
		case (paddr)
			`OFS_FLAGS:    rdata_mux = flags_reg;
			`OFS_GATE:     rdata_mux = gate_reg;
			`OFS_CPL:      rdata_mux = {30'h0, cpl_reg};
			`OFS_SEL:      rdata_mux = {17'h0, sel_reg};
			`OFS_STATUS:   rdata_mux = {16'h0, vec_reg, 3'h0, status_reg};
			`OFS_SAVED:    rdata_mux = saved_reg;
			`OFS_ERRC:     rdata_mux = errc_reg;
			`OFS_DIVIDEND: rdata_mux = dividend_reg;
			`OFS_DIVISOR:  rdata_mux = {15'h0, divisor_reg};
			`OFS_QUOT:     rdata_mux = {16'h0, quot_reg};
			`OFS_TASK:     rdata_mux = {16'h0, task_reg};
			`OFS_LINK:     rdata_mux = {16'h0, link_reg};
			`OFS_IP:       rdata_mux = ip_reg;
			`OFS_NEXT_IP:  rdata_mux = next_ip_reg;
			`OFS_HWVEC:    rdata_mux = {24'h0, hwvec_reg};
			default:       rdata_mux = 32'h0000_0000;
		endcase
	end

	// ********************
	// divide check
	// ********************
	always_comb
	begin
		quot_full = 32'h0000_0000;
		div_fault = 1'b0;
		if (divisor_reg[15:0] == 16'h0000)
			div_fault = 1'b1;
		else if (divisor_reg[`DIV_SIGN_BIT])
		begin
			quot_full = $signed(dividend_reg) / $signed({{16{divisor_reg[15]}}, divisor_reg[15:0]});
			// quotient must fit a signed half word
			div_fault = (quot_full[31:15] != {17{quot_full[15]}});
		end
		else
		begin
			quot_full = dividend_reg / {16'h0, divisor_reg[15:0]};
			div_fault = (quot_full[31:16] != 16'h0000);
		end
	end

	// ********************
	// dispatch control
	// ********************
	assign pin_take = pin_s2_reg && flags_reg[`IE_BIT] && state_reg == exc_pkg::st_idle;
	assign sw_src   = src_reg == exc_pkg::src_soft || src_reg == exc_pkg::src_brk
		|| src_reg == exc_pkg::src_ovf;
	// implicit calls carry no requested level, so only levels of code and gate are compared
	assign priv_fail = (gate_reg[5:4] > cpl_reg)
		|| (sw_src && cpl_reg > gate_reg[3:2]);
	assign start = state_reg == exc_pkg::st_idle && src_reg != exc_pkg::src_exc;

	assign ec.external_event_bit       = ext_reg;
	assign ec.in_table  = (state_reg == exc_pkg::st_idle) ? 1'b1 : sel_reg[14];
	assign ec.local_tbl = sel_reg[13];
	assign ec.index     = (state_reg == exc_pkg::st_idle) ? {5'h00, vec_reg} : sel_reg[12:0];

	always_comb
	begin
		state_next    = state_reg;
		src_next      = src_reg;
		flags_next    = flags_reg;
		gate_next     = gate_reg;
		cpl_next      = cpl_reg;
		sel_next      = sel_reg;
		saved_next    = saved_reg;
		errc_next     = errc_reg;
		dividend_next = dividend_reg;
		divisor_next  = divisor_reg;
		quot_next     = quot_reg;
		task_next     = task_reg;
		link_next     = link_reg;
		ip_next       = ip_reg;
		next_ip_next  = next_ip_reg;
		hwvec_next    = hwvec_reg;
		vec_next      = vec_reg;
		err_next      = err_reg;
		ext_next      = ext_reg;
		status_next   = status_reg;
		ts_next       = 1'b0;
		gp_next       = 1'b0;
		rdata_next    = rd_sel ? rdata_mux : rdata_reg;
		push_valid    = 1'b0;
		push_data     = 32'h0000_0000;
		push_wide     = 1'b1;
		if (wr_en)
		begin
			case (paddr)
				`OFS_FLAGS:    flags_next = pwdata;
				`OFS_GATE:     gate_next = pwdata;
				`OFS_CPL:      cpl_next = pwdata[1:0];
				`OFS_SEL:      sel_next = pwdata[14:0];
				`OFS_DIVIDEND: dividend_next = pwdata;
				`OFS_TASK:     task_next = pwdata[15:0];
				`OFS_IP:       ip_next = pwdata;
				`OFS_NEXT_IP:  next_ip_next = pwdata;
				`OFS_HWVEC:    hwvec_next = pwdata[7:0];
				`OFS_DIVISOR:  divisor_next = pwdata[16:0];
				default:       flags_next = flags_reg;
			endcase
			if (paddr == `OFS_RETURN_FROM_INTERRUPT && state_reg == exc_pkg::st_idle)
			begin
				flags_next[`TRACE_BIT]  = pwdata[`TRACE_BIT];
				flags_next[`V86_BIT]    = pwdata[`V86_BIT];
				flags_next[`RESUME_BIT] = pwdata[`RESUME_BIT];
				flags_next[`NEST_BIT]   = pwdata[`NEST_BIT];
				// the error code stays on the stack; software discards it
				flags_next[`IE_BIT]     = pwdata[`IE_BIT];
			end
			// requests while busy are dropped; status shows busy
			if (paddr == `OFS_REQ && state_reg == exc_pkg::st_idle)
			begin
				vec_next = pwdata[7:0];
				src_next = src_decode(pwdata[10:8]);
				err_next = pwdata[11];
				ext_next = pwdata[12];
				if (src_decode(pwdata[10:8]) == exc_pkg::src_exc)
					src_next = exc_pkg::src_exc;
			end
		end
		case (state_reg)
			exc_pkg::st_idle:
			begin
				if (wr_en && paddr == `OFS_REQ)
				begin
					// exception requests start next cycle through the marker below
					status_next = 5'h01;
					state_next  = exc_pkg::st_idle;
					if (src_decode(pwdata[10:8]) == exc_pkg::src_exc)
						src_next = exc_pkg::src_div;
				end
				else if (wr_en && paddr == `OFS_DIVISOR)
				begin
					divisor_next = pwdata[16:0];
				end
				else if (pin_take && src_reg == exc_pkg::src_exc)
				begin
					vec_next    = hwvec_reg;
					src_next    = exc_pkg::src_pin;
					err_next    = 1'b0;
					ext_next    = 1'b1;
					status_next = 5'h01;
				end
				if (start)
				begin
					if (src_reg == exc_pkg::src_div && vec_reg == `DIVIDE_VEC && !err_reg
						&& !ext_reg && status_reg[2])
						status_next = 5'h05;
					if (priv_fail)
					begin
						// refused gate: report fault with code naming the gate
						gp_next     = 1'b1;
						errc_next   = ec.code;
						status_next = 5'h02;
						src_next    = exc_pkg::src_exc;
					end
					else if (gate_reg[1:0] == `KIND_TASK)
						state_next = exc_pkg::st_task;
					else
						state_next = exc_pkg::st_push_flags;
				end
			end
			exc_pkg::st_push_flags:
			begin
				push_valid = 1'b1;
				push_data  = flags_reg;
				if (push_ready)
				begin
					saved_next = flags_reg;
					state_next = exc_pkg::st_push_ret;
				end
			end
			exc_pkg::st_push_ret:
			begin
				push_valid = 1'b1;
				// a fault returns to the faulting instruction itself
				push_data  = (src_reg == exc_pkg::src_div) ? ip_reg : next_ip_reg;
				if (push_ready)
					state_next = exc_pkg::st_clear;
			end
			exc_pkg::st_clear:
			begin
				flags_next[`TRACE_BIT]  = 1'b0;
				flags_next[`V86_BIT]    = 1'b0;
				flags_next[`RESUME_BIT] = 1'b0;
				flags_next[`NEST_BIT]   = 1'b0;
				if (gate_reg[1:0] == `KIND_INT)
					flags_next[`IE_BIT] = 1'b0;
				// trap gates fall through with interrupt enable untouched
				state_next = err_reg ? exc_pkg::st_push_err : exc_pkg::st_idle;
				if (!err_reg)
					src_next = exc_pkg::src_exc;
			end
			exc_pkg::st_task:
			begin
				link_next      = task_reg;
				task_next      = gate_reg[31:16];
				ts_next        = 1'b1;
				status_next[4] = 1'b1;
				state_next     = err_reg ? exc_pkg::st_push_err : exc_pkg::st_idle;
				if (!err_reg)
					src_next = exc_pkg::src_exc;
			end
			exc_pkg::st_push_err:
			begin
				push_valid = 1'b1;
				push_data  = ec.code;
				push_wide  = gate_reg[6];
				if (push_ready)
				begin
					errc_next      = ec.code;
					status_next[3] = 1'b1;
					state_next     = exc_pkg::st_idle;
					src_next       = exc_pkg::src_exc;
				end
			end
			default:
				state_next = exc_pkg::st_idle;
		endcase
		// pin and software interrupts never carry a code; exception requests keep theirs
		if (start && (src_reg == exc_pkg::src_pin || sw_src))
			err_next = 1'b0;
		// divisor write while idle runs the check; on a fault the quotient is left as it was
		if (wr_en && paddr == `OFS_DIVISOR && state_reg == exc_pkg::st_idle)
			status_next[2] = 1'b0;
		if (src_reg == exc_pkg::src_exc && state_reg == exc_pkg::st_idle && !wr_en
			&& status_reg[0] && !pin_take)
			status_next[0] = 1'b0;
		// divide fault dispatches vector 0 with state untouched
		if (div_go_reg && div_fault)
		begin
			src_next    = exc_pkg::src_div;
			vec_next    = `DIVIDE_VEC;
			err_next    = 1'b0;
			ext_next    = 1'b0;
			status_next = 5'h05;
			quot_next   = quot_reg;
		end
		else if (div_go_reg)
			quot_next = quot_full[15:0];
	end

	// ********************
	// divide launch: separate so the check sees the stored operands
	// ********************
	logic div_go_reg, div_go_next;
	always_comb
	begin
		div_go_next = wr_en && paddr == `OFS_DIVISOR && state_reg == exc_pkg::st_idle;
	end

	// ********************
	// registers
	// ********************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg    <= exc_pkg::st_idle;
			src_reg      <= exc_pkg::src_exc;
			flags_reg    <= `FLAGS_RESET;
			gate_reg     <= 32'h0000_0000;
			cpl_reg      <= 2'h0;
			sel_reg      <= 15'h0000;
			saved_reg    <= 32'h0000_0000;
			errc_reg     <= 32'h0000_0000;
			dividend_reg <= 32'h0000_0000;
			divisor_reg  <= 17'h00000;
			quot_reg     <= 16'h0000;
			task_reg     <= 16'h0000;
			link_reg     <= 16'h0000;
			ip_reg       <= 32'h0000_0000;
			next_ip_reg  <= 32'h0000_0000;
			hwvec_reg    <= 8'h00;
			vec_reg      <= 8'h00;
			err_reg      <= 1'b0;
			ext_reg      <= 1'b0;
			status_reg   <= 5'h00;
			ts_reg       <= 1'b0;
			gp_reg       <= 1'b0;
			rdata_reg    <= 32'h0000_0000;
			div_go_reg   <= 1'b0;
		end
		else if (ce)
		begin
			state_reg    <= state_next;
			flags_reg    <= flags_next;
			gate_reg     <= gate_next;
			cpl_reg      <= cpl_next;
			sel_reg      <= sel_next;
			saved_reg    <= saved_next;
			errc_reg     <= errc_next;
			dividend_reg <= dividend_next;
			divisor_reg  <= divisor_next;
			task_reg     <= task_next;
			link_reg     <= link_next;
			ip_reg       <= ip_next;
			next_ip_reg  <= next_ip_next;
			hwvec_reg    <= hwvec_next;
			ext_reg      <= ext_next;
			ts_reg       <= ts_next;
			gp_reg       <= gp_next;
			rdata_reg    <= rdata_next;
			div_go_reg   <= div_go_next;
			src_reg      <= src_next;
			vec_reg      <= vec_next;
			err_reg      <= err_next;
			status_reg   <= status_next;
			quot_reg     <= quot_next;
		end
	end

	// pin comes from outside the clock domain
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
		end
		else if (ce)
		begin
			pin_s1_reg <= maskable_interrupt_pin;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign task_switch = ts_reg;
	assign gp_fault    = gp_reg;
endmodule // exc_dispatch

// [src/exc_pkg.sv]
// types shared by the exception dispatch block
package exc_pkg;
	typedef enum logic [2:0] {st_idle, st_push_flags, st_push_ret, st_clear, st_task, st_push_err}
		disp_state_t;
	typedef enum logic [2:0] {src_exc, src_pin, src_soft, src_brk, src_ovf, src_div} src_t;
endpackage

// [test/exc_dispatch_asserts.sv]
// port checker for the exception dispatch unit
`timescale 1ns/1ns
module exc_dispatch_asserts
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        maskable_interrupt_pin,
	input wire logic        push_ready,
	input wire logic        push_valid,
	input wire logic [31:0] push_data,
	input wire logic        push_wide,
	input wire logic        task_switch,
	input wire logic        gp_fault
);
	// ********************
	// port properties
	// ********************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	ready_phase_a: assert property (pready == (psel && penable && ce))
		else $error("ready outside access phase");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	rdata_hold_a: assert property (!(psel && ce) |=> $stable(prdata))
		else $error("read data moved while unselected");
	push_hold_a: assert property (
		push_valid && !push_ready && ce |=> push_valid && $stable(push_data) && $stable(push_wide))
		else $error("push dropped or changed while stalled");
	gp_pulse_a: assert property (gp_fault |=> !gp_fault)
		else $error("protection fault longer than one cycle");
	gp_no_push_a: assert property (gp_fault |-> !push_valid ##1 !push_valid)
		else $error("push offered after refused dispatch");
	task_pulse_a: assert property (task_switch |=> !task_switch)
		else $error("task switch longer than one cycle");
	task_excl_a: assert property (task_switch |-> !gp_fault)
		else $error("task switch together with protection fault");
	cover property (gp_fault);
	cover property (task_switch);
	cover property (push_valid && push_ready && !push_wide);
endmodule // exc_dispatch_asserts
bind exc_dispatch exc_dispatch_asserts u_exc_dispatch_asserts (.clk(clk), .rst(rst), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.maskable_interrupt_pin(maskable_interrupt_pin), .push_ready(push_ready),
	.push_valid(push_valid), .push_data(push_data), .push_wide(push_wide),
	.task_switch(task_switch), .gp_fault(gp_fault));

// [test/exc_dispatch_test.sv]
// self-checking bench for the exception dispatch unit
`timescale 1ns/1ns
`include "exc_consts.svh"
module exc_dispatch_test;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, pin = 1'b0, pr = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r = 32'h94534bed;
	logic [31:0] prdata, pd, q[$];
	logic        pready, pslverr, pv, pw, ts, gp, w[$];
	int          fails, cmp_count, gp_n, ts_n;
	localparam logic [31:0] clr_mask = (32'h1 << `TRACE_BIT) | (32'h1 << `V86_BIT)
		| (32'h1 << `RESUME_BIT) | (32'h1 << `NEST_BIT);
	localparam logic [31:0] ret_mask = clr_mask | (32'h1 << `IE_BIT);
	exc_dispatch u_exc_dispatch (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .maskable_interrupt_pin(pin), .push_ready(pr), .push_valid(pv),
		.push_data(pd), .push_wide(pw), .task_switch(ts), .gp_fault(gp));
	// ********************
	// helpers
	// ********************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_fl(input logic [31:0] f, input logic [1:0] k);
		logic [31:0] m;
		m = clr_mask;
		if (k == `KIND_INT)
			m[`IE_BIT] = 1'b1;
		return f & ~m;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tout();
		fails++;
		final_report();
	endtask
	task automatic apb(input logic dir, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= dir;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			tout();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        e;
		apb(1'b1, a, d, x, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
		logic [31:0] x;
		logic        e;
		apb(1'b0, a, 32'h0, x, e);
		chk(x & m, ex & m);
	endtask
	// dispatch may start two cycles after its trigger, so busy is polled after that
	task automatic idle();
		logic [31:0] s;
		logic        e;
		int          n;
		repeat (2) @(posedge clk);
		n = 0;
		do
		begin
			apb(1'b0, `OFS_STATUS, 32'h0, s, e);
			n++;
		end
		while (s[0] !== 1'b0 && n < 50);
		if (s[0] !== 1'b0)
			tout();
	endtask
	task automatic disp(input logic [31:0] req, gate, fl, current_privilege_level);
		wr(`OFS_FLAGS, fl);
		wr(`OFS_GATE, gate);
		wr(`OFS_CPL, current_privilege_level);
		q.delete();
		w.delete();
		gp_n = 0;
		ts_n = 0;
		wr(`OFS_REQ, req);
		idle();
	endtask
	// ********************
	// stimulus and monitor
	// ********************
	initial
		forever #2 clk = ~clk;
	always @(posedge clk)
	begin
		r <= lfsr(r);
		pr <= r[0] | r[1];
		if (pv && pr)
		begin
			q.push_back(pd);
			w.push_back(pw);
		end
		gp_n += gp;
		ts_n += ts;
	end
	initial
	begin
		logic [31:0] v, v2, fl, ec, old, s;
		logic [7:0]  vec;
		logic [2:0]  src;
		logic [1:0]  kind, current_privilege_level, descriptor_privilege_level, tgt;
		logic        e, errf, external_event_bit, ok, code;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(`OFS_FLAGS, `FLAGS_RESET, '1);
		apb(1'b0, 8'h80, 32'h0, s, e);
		chk({31'h0, e}, 32'h1);
		chk(s, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			v = r;
			v2 = lfsr(v);
			{errf, src, vec} = {v[11], v[10:8] % 3'h5, v[7:0]};
			kind = (v[14:13] == 2'h3) ? `KIND_TRAP : v[14:13];
			{descriptor_privilege_level, current_privilege_level, tgt} = {v[16:15], v[18:17], 2'h0};
			if (i == 0) {src, current_privilege_level, descriptor_privilege_level} = {`SRC_EXC, 2'h3, 2'h0};
			if (i == 1) {src, current_privilege_level, descriptor_privilege_level} = {`SRC_SOFT, 2'h3, 2'h2};
			if (i == 2) {src, current_privilege_level, tgt} = {`SRC_EXC, 2'h0, 2'h1};
			if (i == 3) {src, errf, kind} = {`SRC_EXC, 1'b1, `KIND_TASK};
			if (i == 4) {src, errf, kind} = {`SRC_SOFT, 1'b1, `KIND_INT};
			external_event_bit = v[12] & (src < `SRC_SOFT);
			ok = (tgt <= current_privilege_level) && (src < `SRC_SOFT || current_privilege_level <= descriptor_privilege_level);
			code = (src == `SRC_EXC) && errf;
			fl = ((v ^ v2) & ret_mask) | `FLAGS_RESET;
			ec = {16'h0, v2[12:0], v2[14] & ~v2[13], v2[13], external_event_bit};
			apb(1'b0, `OFS_TASK, 32'h0, old, e);
			wr(`OFS_SEL, {17'h0, v2[13], v2[14] & ~v2[13], v2[12:0]});
			disp({19'h0, external_event_bit, errf, src, vec}, {v2[31:16], 9'h0, v[19], tgt, descriptor_privilege_level, kind},
				fl, {30'h0, current_privilege_level});
			if (!ok)
			begin
				chk(32'(gp_n), 32'h1);
				chk(32'(q.size()), 32'h0);
				rdc(`OFS_ERRC, {21'h0, vec, 2'h1, external_event_bit}, '1);
			end
			else if (kind == `KIND_TASK)
			begin
				chk(32'(ts_n), 32'h1);
				rdc(`OFS_LINK, old, '1);
				rdc(`OFS_TASK, {16'h0, v2[31:16]}, '1);
				chk(32'(q.size()), 32'(code));
				if (code) chk(q[0], ec);
			end
			else
			begin
				chk(32'(gp_n), 32'h0);
				chk(32'(q.size()), 32'd2 + 32'(code));
				chk(q[0], fl);
				rdc(`OFS_FLAGS, exp_fl(fl, kind), '1);
				if (code) chk(q[2], ec);
				if (code) chk(32'(w[2]), 32'(v[19]));
			end
			wr(`OFS_RETURN_FROM_INTERRUPT, v2);
			rdc(`OFS_FLAGS, v2, ret_mask);
		end
		wr(`OFS_GATE, 32'h0);
		wr(`OFS_CPL, 32'h0);
		wr(`OFS_IP, v);
		wr(`OFS_DIVIDEND, 32'h0001_2345);
		for (int k = 0; k < 4; k++)
		begin
			q.delete();
			wr(`OFS_DIVISOR, (k == 0) ? 32'h10 : ((k == 1) ? 32'h1_0000
				: ((k == 2) ? 32'h1 : 32'h1_fff0)));
			idle();
			rdc(`OFS_QUOT, (k == 3) ? 32'hedcc : 32'h1234, 32'hffff);
			rdc(`OFS_STATUS, (k == 1 || k == 2) ? 32'h4 : 32'h0,
				(k == 1 || k == 2) ? 32'hff04 : 32'h4);
			chk(32'(q.size()), (k == 1 || k == 2) ? 32'h2 : 32'h0);
			if (k == 1 || k == 2) chk(q[1], v);
		end
		wr(`OFS_FLAGS, ret_mask | `FLAGS_RESET);
		wr(`OFS_HWVEC, 32'h20);
		q.delete();
		pin <= 1'b1;
		// with the enable low the pin must not even reach the synchroniser
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		chk(32'(q.size()), 32'h0);
		ce <= 1'b1;
		for (int n = 0; n < 60 && q.size() < 2; n++)
			@(posedge clk);
		pin <= 1'b0;
		idle();
		chk(32'(q.size()), 32'h2);
		rdc(`OFS_FLAGS, exp_fl(ret_mask | `FLAGS_RESET, `KIND_INT), '1);
		final_report();
	end
endmodule // exc_dispatch_test
